// file: mps_sequencer.sv
// motion program sequencer, two axes, with apb register access
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"
module mps_sequencer
   import mps_pkg::*;
#(
   parameter int NAX = 2,
   parameter int DEPTH = 8,
   parameter int PW = 8,
   parameter int IMEM = 256
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // axis status from trajectory generators
   input wire logic [NAX-1:0] drive_en_cmd,
   input wire logic [NAX-1:0] drive_enabled,
   input wire logic [NAX-1:0] pos_valid,
   input wire logic [NAX-1:0] axis_moving,
   input wire logic [NAX-1:0] force_vel,
   input wire logic [NAX-1:0] stop_err,
   input wire logic [NAX-1:0] ot_switch,
   input wire logic [NAX-1:0] in_limits,
   input wire logic [NAX-1:0] move_done,
   // external condition inputs
   input wire logic [3:0] external_condition_input,
   // commands to trajectory generators
   output logic [NAX-1:0] move_start,
   output logic [NAX-1:0] move_cont,
   output logic [NAX-1:0] move_stop,
   output logic [NAX*16-1:0] move_target,
   output logic [NAX*16-1:0] move_vel,
   output logic [NAX*16-1:0] move_acc,
   output logic [NAX-1:0] program_active
);
   localparam int SYNC_CYC = `MPS_SYNC_CYC;
   // ==========================================================
   // storage: instructions and parameters
   logic [15:0] imem [IMEM];
   logic [15:0] param_r [PW];
   logic [31:0] ctrl_r;
   logic [15:0] limit_r;
   // program table: entry address and two-axis class per program
   logic [7:0] entry_r [64];
   logic [63:0] twoax_r;
   logic [63:0] valid_r;
   // ==========================================================
   // apb decode, zero wait states
   logic wr_en;
   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   logic [7:0] iaddr_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= 32'h0000_0000;
         limit_r <= 16'h7FFF;
         iaddr_r <= 8'h00;
         twoax_r <= 64'h0;
         valid_r <= 64'h0;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            `MPS_OFF_CTRL: ctrl_r <= pwdata;
            `MPS_OFF_LIM: limit_r <= pwdata[15:0];
            `MPS_OFF_PROG:
            begin
               // prog entry: [21:16] prog, [8] two-axis, [7:0] address
               valid_r[pwdata[21:16]] <= 1'b1;
               twoax_r[pwdata[21:16]] <= pwdata[8];
            end
            `MPS_OFF_INST: iaddr_r <= iaddr_r + 8'h01;
            default: ;
         endcase
      end
   end
   // memories written without reset
   always_ff @(posedge pclk)
   begin
      if (wr_en && paddr == `MPS_OFF_INST)
         imem[iaddr_r] <= pwdata[15:0];
      if (wr_en && paddr == `MPS_OFF_PROG)
         entry_r[pwdata[21:16]] <= pwdata[7:0];
   end
   // ==========================================================
   // shared program state
   mps_state_t st_r;
   logic [7:0] pc_r;
   logic [7:0] stk_r [DEPTH];
   logic [3:0] sp_r;
   logic two_r;
   logic sub_ok_r;
   logic [1:0] own_r;
   logic [7:0] blk_r;
   logic [15:0] wait_r;
   logic [15:0] vel_r, acc_r, pend_vel, pend_acc;
   logic pend_jmp;
   logic [7:0] pend_tgt;
   logic [7:0] prog_sel;
   logic sync_r, err_r;
   logic [15:0] ins;
   mps_op_t op;
   logic [1:0] ax;
   logic [15:0] opnd;
   assign prog_sel = ctrl_r[15:8];
   assign ins = imem[pc_r];
   assign op = mps_op_t'(ins[`MPS_OP_HI:`MPS_OP_LO]);
   assign ax = ins[`MPS_AX_HI:`MPS_AX_LO];
   // operand from parameter register when arg msb is set
   assign opnd = ins[`MPS_ARG_HI] ? param_r[ins[2:0]] : {8'h00, ins[7:0]};
   // ==========================================================
   // start qualification and abort
   logic [NAX-1:0] ax_ready, ax_kill, ax_sel;
   genvar g;
   for (g = 0; g < NAX; g++)
   begin : g_ax
      assign ax_ready[g] = drive_en_cmd[g] & drive_enabled[g] & pos_valid[g]
         & ~axis_moving[g] & ~program_active[g] & ~ctrl_r[`MPS_CB_ABORT]
         & ~force_vel[g] & (in_limits[g] | ctrl_r[`MPS_CB_CONT0 + g])
         & (ot_switch[g] | ~ctrl_r[`MPS_CB_OTEN]);
      // axes named by the current instruction
      assign ax_sel[g] = own_r[g] & (ax == 2'd0 || ax == 2'(g + 1));
      assign ax_kill[g] = own_r[g] & (ctrl_r[`MPS_CB_ABORT] | ~drive_en_cmd[g]
         | (ctrl_r[`MPS_CB_OTEN] & ~ot_switch[g]) | stop_err[g]);
   end
   logic [5:0] pn;
   logic two_req, can_start;
   logic [1:0] want;
   assign pn = prog_sel[5:0];
   assign two_req = twoax_r[pn];
   assign want = two_req ? 2'b11 : (ctrl_r[`MPS_CB_RUN1] ? 2'b10 : 2'b01);
   // both axes for two-axis, valid stored program
   assign can_start = (ctrl_r[`MPS_CB_RUN0] | ctrl_r[`MPS_CB_RUN1])
      & valid_r[pn] & ((ax_ready & want) == want) & (st_r == MPS_IDLE);
   // software limit check on a move operand
   logic lim_bad;
   assign lim_bad = (opnd > limit_r)
      & ~(|(own_r & ctrl_r[`MPS_CB_CONT1:`MPS_CB_CONT0]));
   // ==========================================================
   // sequencer: one fetch per cycle, stalled at each motion block until it ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= MPS_IDLE;
         pc_r <= `MPS_PC_RST;
         sp_r <= 4'h0;
         own_r <= 2'b00;
         two_r <= 1'b0;
         sub_ok_r <= 1'b0;
         blk_r <= 8'h00;
         vel_r <= 16'h0000;
         acc_r <= 16'h0000;
         pend_vel <= 16'h0000;
         pend_acc <= 16'h0000;
         pend_jmp <= 1'b0;
         pend_tgt <= 8'h00;
         sync_r <= 1'b0;
         err_r <= 1'b0;
         wait_r <= 16'h0000;
         move_start <= '0;
         move_cont <= '0;
         move_stop <= '0;
         move_target <= '0;
      end
      else
      begin
         move_start <= '0;
         move_stop <= '0;
         // abort ends run and frees the axis
         if (|ax_kill)
         begin
            st_r <= MPS_IDLE;
            own_r <= 2'b00;
            move_stop <= own_r;
         end
         else
         begin
            unique case (st_r)
               MPS_IDLE:
                  // one program at a time for both axes, start on request
                  if (can_start)
                  begin
                     own_r <= want;
                     two_r <= two_req;
                     sub_ok_r <= (pn != 6'd0);
                     pc_r <= entry_r[pn];
                     sp_r <= 4'h0;
                     err_r <= 1'b0;
                     st_r <= MPS_FETCH;
                  end
               MPS_FETCH:
               begin
                  pc_r <= pc_r + 8'h01;
                  unique case (op)
                     MPS_OP_CALL:
                     begin
                        if (!sub_ok_r || sp_r == 4'(DEPTH)
                           || twoax_r[ins[5:0]] != two_r)
                           begin
                              err_r <= 1'b1;
                              st_r <= MPS_DONE;
                           end
                        else
                        begin
                           stk_r[sp_r[2:0]] <= pc_r + 8'h01;
                           sp_r <= sp_r + 4'h1;
                           pc_r <= entry_r[ins[5:0]];
                        end
                     end
                     MPS_OP_RET:
                        if (sp_r != 4'h0)
                        begin
                           pc_r <= stk_r[sp_r[2:0] - 3'h1];
                           sp_r <= sp_r - 4'h1;
                        end
                     MPS_OP_JUMP:
                        // conditional jump latched for next motion
                        if (ins[`MPS_AX_HI])
                           pc_r <= ins[7:0];
                        else if (external_condition_input[ins[`MPS_CD_HI:`MPS_CD_LO]])
                        begin
                           pend_jmp <= 1'b1;
                           pend_tgt <= ins[7:0];
                        end
                     MPS_OP_BLOCK: blk_r <= ins[7:0];
                     MPS_OP_SYNC:
                        if (two_r)
                           sync_r <= 1'b1;
                        else
                        begin
                           err_r <= 1'b1;
                           st_r <= MPS_DONE;
                        end
                     MPS_OP_VELOC: pend_vel <= opnd;
                     MPS_OP_ACCEL: pend_acc <= opnd;
                     MPS_OP_NULL, MPS_OP_LOAD: ;
                     default:
                     begin
                        vel_r <= pend_vel;
                        acc_r <= pend_acc;
                        // a taken jump replaces this block's motion
                        pc_r <= pend_jmp ? pend_tgt : pc_r;
                        pend_jmp <= 1'b0;
                        st_r <= pend_jmp ? MPS_FETCH : MPS_HOLD;
                     end
                  endcase
               end
               MPS_HOLD:
               begin
                  // hold for all owned axes idle then start the axes a move names, or stop them for dwell and wait
                  if (&(~axis_moving | ~own_r))
                  begin
                     sync_r <= 1'b0;
                     pc_r <= pc_r;
                     if ((op == MPS_OP_POSITIONING_MOVE || op == MPS_OP_CONTINUOUS_MOVE) && lim_bad)
                        st_r <= MPS_DONE;
                     else if (op == MPS_OP_END)
                        st_r <= MPS_DONE;
                     else
                     begin
                        for (int a = 0; a < NAX; a++)
                        begin
                           // axis field selects; zero means both
                           if (own_r[a] && (ax == 2'd0 || ax == 2'(a + 1)))
                           begin
                              move_start[a] <= op == MPS_OP_POSITIONING_MOVE
                                 || op == MPS_OP_CONTINUOUS_MOVE;
                              move_stop[a] <= !(op == MPS_OP_POSITIONING_MOVE
                                 || op == MPS_OP_CONTINUOUS_MOVE);
                              move_cont[a] <= op == MPS_OP_CONTINUOUS_MOVE;
                              move_target[a*16 +: 16] <= opnd;
                           end
                        end
                        wait_r <= (op == MPS_OP_DWELL) ? opnd : 16'h0000;
                        st_r <= MPS_RUN;
                     end
                  end
               end
               MPS_RUN:
               begin
                  // next block fetched as soon as the move ends
                  if (wait_r != 16'h0000)
                     wait_r <= wait_r - 16'h0001;
                  else if (op != MPS_OP_WAIT
                     || external_condition_input[ins[`MPS_CD_HI:`MPS_CD_LO]])
                     if (&(move_done | ~ax_sel) || op == MPS_OP_DWELL
                        || op == MPS_OP_WAIT)
                     begin
                        pc_r <= pc_r + 8'h01;
                        st_r <= MPS_FETCH;
                     end
               end
               MPS_DONE:
               begin
                  own_r <= 2'b00;
                  move_stop <= own_r;
                  st_r <= MPS_IDLE;
               end
               default: st_r <= MPS_IDLE;
            endcase
         end
      end
   end
   assign program_active = own_r;
   // ==========================================================
   // parameter load from program or host
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < PW; i++)
            param_r[i] <= 16'h0000;
      end
      else if (st_r == MPS_FETCH && op == MPS_OP_LOAD)
         param_r[ins[10:8]] <= {8'h00, ins[7:0]};
      else if (wr_en && paddr == `MPS_OFF_PLD)
         param_r[pwdata[18:16]] <= pwdata[15:0];
   end
   // held rates on the axis outputs
   always_comb
   begin
      for (int a = 0; a < NAX; a++)
      begin
         move_vel[a*16 +: 16] = vel_r;
         move_acc[a*16 +: 16] = acc_r;
      end
   end
   // ==========================================================
   // read mux, status and block number
   always_comb
   begin
      unique case (paddr)
         `MPS_OFF_CTRL: prdata = ctrl_r;
         `MPS_OFF_STAT: prdata = {22'h0, err_r, sync_r, 1'b0,
            st_r, own_r};
         `MPS_OFF_BLK: prdata = {24'h0, blk_r};
         `MPS_OFF_LIM: prdata = {16'h0, limit_r};
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// file: mps_defs.svh
// constants for the motion program sequencer
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH
// ==========================================================
// register byte offsets
`define MPS_OFF_CTRL 12'h000
`define MPS_OFF_STAT 12'h004
`define MPS_OFF_PLD 12'h008
`define MPS_OFF_BLK 12'h00C
`define MPS_OFF_PROG 12'h010
`define MPS_OFF_INST 12'h014
`define MPS_OFF_LIM 12'h018
// ==========================================================
// control bit positions
`define MPS_CB_RUN0 0
`define MPS_CB_RUN1 1
`define MPS_CB_ABORT 2
`define MPS_CB_OTEN 3
`define MPS_CB_CONT0 4
`define MPS_CB_CONT1 5
// ==========================================================
// instruction fields: op[15:12] axis[11:10] cond[9:8] arg[7:0]
`define MPS_OP_HI 15
`define MPS_OP_LO 12
`define MPS_AX_HI 11
`define MPS_AX_LO 10
`define MPS_CD_HI 9
`define MPS_CD_LO 8
`define MPS_ARG_HI 7
// ==========================================================
// timing
`define MPS_CLK_HZ 10000000
`define MPS_SYNC_MS 2
`define MPS_SYNC_CYC (`MPS_CLK_HZ / 1000 * `MPS_SYNC_MS)
`define MPS_PC_RST 8'h00
`endif

// file: mps_pkg.sv
// types for the motion program sequencer
package mps_pkg;
   typedef enum logic [3:0] {
      MPS_OP_NULL = 4'h0, MPS_OP_CALL = 4'h1, MPS_OP_JUMP = 4'h2,
      MPS_OP_BLOCK = 4'h3, MPS_OP_SYNC = 4'h4, MPS_OP_LOAD = 4'h5,
      MPS_OP_ACCEL = 4'h6, MPS_OP_VELOC = 4'h7, MPS_OP_POSITIONING_MOVE = 4'h8,
      MPS_OP_CONTINUOUS_MOVE = 4'h9, MPS_OP_DWELL = 4'hA, MPS_OP_WAIT = 4'hB,
      MPS_OP_END = 4'hC, MPS_OP_RET = 4'hD
   } mps_op_t;
   typedef enum logic [4:0] {
      MPS_IDLE = 5'b00001, MPS_FETCH = 5'b00010, MPS_HOLD = 5'b00100,
      MPS_RUN = 5'b01000, MPS_DONE = 5'b10000
   } mps_state_t;
endpackage

// file: mps_sequencer_properties.sv
// assertion checker for the motion program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"
module mps_sequencer_properties
#(
   parameter int NAX = 2
)
(
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // axis side
   input wire logic [NAX-1:0] drive_en_cmd,
   input wire logic [NAX-1:0] drive_enabled,
   input wire logic [NAX-1:0] pos_valid,
   input wire logic [NAX-1:0] axis_moving,
   input wire logic [NAX-1:0] force_vel,
   input wire logic [NAX-1:0] stop_err,
   input wire logic [NAX-1:0] ot_switch,
   input wire logic [NAX-1:0] move_start,
   input wire logic [NAX-1:0] program_active
);
   // ==========================================================
   // control bits mirrored from bus writes
   logic abort_r;
   logic ot_en_r;
   wire logic [NAX-1:0] ok_w;
   wire logic [NAX-1:0] ot_bad_w;
   // the checker cannot see inside, so it copies the abort and overtravel-enable bits of the control word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         abort_r <= 1'b0;
         ot_en_r <= 1'b0;
      end
      else if (psel && penable && pwrite && paddr == `MPS_OFF_CTRL)
      begin
         abort_r <= pwdata[`MPS_CB_ABORT];
         ot_en_r <= pwdata[`MPS_CB_OTEN];
      end
   end
   // start readiness and open switches per axis
   assign ok_w = drive_en_cmd & drive_enabled & pos_valid & ~force_vel;
   assign ot_bad_w = ot_en_r ? ~ot_switch : '0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // masked axes drop program-active within two edges
   sequence s_gone(m);
      ##[1:2] (program_active & m) == '0;
   endsequence
   AST_ZERO_WAIT:
   assert property (psel && penable |-> pready && !pslverr)
      else $error("apb access not answered at once");
   AST_START_PULSE:
   assert property (|move_start |=> (move_start & $past(move_start)) == '0)
      else $error("move start longer than one cycle");
   AST_START_ACTIVE:
   assert property ((move_start & ~program_active) == '0)
      else $error("move start without a program");
   AST_START_STILL:
   assert property (|move_start |-> (move_start & $past(axis_moving)) == '0)
      else $error("move start while axis moving");
   AST_PREREQ:
   assert property ((program_active & ~$past(program_active)
      & ~$past(ok_w & ~axis_moving)) == '0)
      else $error("program started without prerequisites");
   AST_ABORT_ENDS:
   assert property (abort_r |-> ##[0:2] program_active == '0)
      else $error("abort did not end program");
   AST_DRIVE_OFF_ENDS:
   assert property (|(program_active & ~drive_en_cmd) |-> s_gone(~drive_en_cmd))
      else $error("drive off did not end program");
   AST_STOP_ERR_ENDS:
   assert property (|(program_active & stop_err) |-> s_gone(stop_err))
      else $error("stop error did not end program");
   AST_OT_ENDS:
   assert property (|(program_active & ot_bad_w) |-> s_gone(ot_bad_w))
      else $error("open switch did not end program");
endmodule
bind mps_sequencer mps_sequencer_properties #(.NAX(NAX)) u_props
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .drive_en_cmd, .drive_enabled, .pos_valid, .axis_moving,
   .force_vel, .stop_err, .ot_switch, .move_start, .program_active
);
`default_nettype wire

// file: mps_axis_model.sv
// trajectory generator stand-in for both axes
`timescale 1ns/1ps
`default_nettype none
module mps_axis_model
#(
   parameter int NAX = 2
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // commands and move length
   input wire logic [NAX-1:0] move_start,
   input wire logic [NAX-1:0] move_stop,
   input wire logic [7:0] dur,
   // status back
   output logic [NAX-1:0] axis_moving,
   output logic [NAX-1:0] move_done
);
   // ==========================================================
   // per-axis move timer
   int cnt [NAX];
   // motion and stop
   // a stop cuts the move short without done, as a real drive would
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         axis_moving <= '0;
         move_done <= '0;
         cnt <= '{default: 0};
      end
      else
         for (int i = 0; i < NAX; i++)
         begin
            move_done[i] <= 1'b0;
            if (move_stop[i])
            begin
               axis_moving[i] <= 1'b0;
               cnt[i] <= 0;
            end
            else if (move_start[i])
            begin
               axis_moving[i] <= 1'b1;
               cnt[i] <= int'(dur);
            end
            else if (cnt[i] == 1)
            begin
               axis_moving[i] <= 1'b0;
               move_done[i] <= 1'b1;
               cnt[i] <= 0;
            end
            else if (cnt[i] > 1)
               cnt[i] <= cnt[i] - 1;
         end
   end
endmodule
`default_nettype wire

// file: tb_motion_program_sequencer.sv
// self-checking bench for the motion program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"
module tb_motion_program_sequencer import mps_pkg::*;;
   // ==========================================================
   // stimulus and observed signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [6:0] bad = 7'h00;
   logic [3:0] external_condition_input = 4'h0;
   logic [7:0] dur = 8'h04;
   logic [31:0] ctl_x = 32'h8;
   wire logic [1:0] drive_en_cmd = {2{~bad[0]}};
   wire logic [1:0] drive_enabled = {2{~bad[1]}};
   wire logic [1:0] pos_valid = {2{~bad[2]}};
   wire logic [1:0] force_vel = {2{bad[3]}};
   wire logic [1:0] in_limits = {2{~bad[4]}};
   wire logic [1:0] ot_switch = {2{~bad[5]}};
   wire logic [1:0] stop_err = {2{bad[6]}};
   wire logic [31:0] prdata, move_target, move_vel, move_acc;
   wire logic pready, pslverr;
   wire logic [1:0] axis_moving, move_done, move_start, move_cont;
   wire logic [1:0] move_stop, program_active;
   int failures = 0, comparisons = 0, cyc = 0;
   int ns [2] = '{0, 0};
   int st [2] = '{0, 0};
   logic [15:0] tg [2];
   logic [15:0] img [16];
   mps_sequencer u_mps_sequencer
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .drive_en_cmd, .drive_enabled, .pos_valid,
      .axis_moving, .force_vel, .stop_err, .ot_switch, .in_limits,
      .move_done, .external_condition_input, .move_start, .move_cont,
      .move_stop, .move_target, .move_vel, .move_acc, .program_active
   );
   mps_axis_model u_mps_axis_model
   (
      .pclk, .presetn, .move_start, .move_stop, .dur, .axis_moving,
      .move_done
   );
   // clock and cycle count
   always #50 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   // start pulses are one cycle wide, so they are caught here
   always @(negedge pclk)
   begin
      for (int i = 0; i < 2; i++)
         if (move_start[i] === 1'b1)
         begin
            ns[i]++;
            st[i] = cyc;
            tg[i] = move_target[i*16 +: 16];
         end
   end
   function automatic logic [15:0] ins(input mps_op_t op,
      input logic [1:0] ax, input logic [1:0] cd, input logic [7:0] arg);
      return {op, ax, cd, arg};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 50, 1'b1);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic wait_n(input int i, input int k);
      int n;
      n = 0;
      while (ns[i] < k && n < 3000)
      begin
         @(negedge pclk);
         n++;
      end
      chk(ns[i] >= k, 1'b1);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while ((program_active | axis_moving) !== 2'b00 && n < 3000)
      begin
         @(negedge pclk);
         n++;
      end
      chk(program_active, 2'b00);
   endtask
   // run bits are dropped again once the program is seen active or 20 cycles pass
   task automatic run(input logic [7:0] p, input logic [1:0] m,
      input logic ok);
      int n;
      wr(`MPS_OFF_CTRL, ctl_x | {16'h0, p, 6'h0, m});
      n = 0;
      while ((program_active & m) !== m && n < 20)
      begin
         @(negedge pclk);
         n++;
      end
      chk((program_active & m) === m, ok);
      wr(`MPS_OFF_CTRL, ctl_x | {16'h0, p, 8'h0});
   endtask
   // main sequence
   initial
   begin
      logic [31:0] q;
      int v, pv, lbl, c, k, j;
      void'($urandom(32'h499527A2));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `MPS_OFF_LIM, 32'h0, q);
      chk(q, 32'h7FFF);
      wr(12'h0FC, 32'hFFFFFFFF);
      apb(1'b0, 12'h0FC, 32'h0, q);
      chk(q, 32'h0);
      v = $urandom_range(127, 1);
      pv = $urandom_range(32'h7FFE, 1);
      lbl = $urandom_range(255, 1);
      c = $urandom_range(3, 0);
      img = '{ins(MPS_OP_VELOC, 2'd1, 2'd0, v[7:0]),
         ins(MPS_OP_BLOCK, 2'd0, 2'd0, lbl[7:0]),
         ins(MPS_OP_POSITIONING_MOVE, 2'd1, 2'd0, 8'h82),
         ins(MPS_OP_POSITIONING_MOVE, 2'd1, 2'd0, 8'h2A),
         ins(MPS_OP_END, 2'd0, 2'd0, 8'h00),
         ins(MPS_OP_JUMP, 2'd0, c[1:0], 8'h08),
         ins(MPS_OP_POSITIONING_MOVE, 2'd1, 2'd0, 8'h11),
         ins(MPS_OP_END, 2'd0, 2'd0, 8'h00),
         ins(MPS_OP_POSITIONING_MOVE, 2'd1, 2'd0, 8'h22),
         ins(MPS_OP_END, 2'd0, 2'd0, 8'h00),
         ins(MPS_OP_SYNC, 2'd0, 2'd0, 8'h00),
         ins(MPS_OP_POSITIONING_MOVE, 2'd1, 2'd0, 8'h33),
         ins(MPS_OP_POSITIONING_MOVE, 2'd2, 2'd0, 8'h44),
         ins(MPS_OP_END, 2'd0, 2'd0, 8'h00),
         ins(MPS_OP_POSITIONING_MOVE, 2'd1, 2'd0, 8'h55),
         ins(MPS_OP_END, 2'd0, 2'd0, 8'h00)};
      for (k = 0; k < 16; k++)
         wr(`MPS_OFF_INST, {16'h0, img[k]});
      wr(`MPS_OFF_PROG, 32'h00010000);
      wr(`MPS_OFF_PROG, 32'h00020005);
      wr(`MPS_OFF_PROG, 32'h0003010A);
      wr(`MPS_OFF_PROG, 32'h0004000E);
      wr(`MPS_OFF_PLD, {13'h0, 3'd2, pv[15:0]});
      dur <= 8'($urandom_range(30, 2));
      run(8'd1, 2'b01, 1'b1);
      wait_n(0, 1);
      chk(tg[0], pv);
      chk(move_vel[15:0], v);
      wait_n(0, 2);
      chk(tg[0], 32'h2A);
      chk(move_vel[15:0], v);
      wait_idle();
      apb(1'b0, `MPS_OFF_BLK, 32'h0, q);
      chk(q & 32'hFF, lbl);
      for (k = 0; k < 2; k++)
      begin
         external_condition_input <= k ? 4'h1 << c : ~(4'h1 << c);
         j = ns[0];
         run(8'd2, 2'b01, 1'b1);
         wait_n(0, j + 1);
         chk(tg[0], k ? 32'h22 : 32'h11);
         wait_idle();
      end
      j = ns[0];
      k = ns[1];
      run(8'd3, 2'b11, 1'b1);
      wait_n(0, j + 1);
      wait_n(1, k + 1);
      chk((st[0] > st[1] ? st[0] - st[1] : st[1] - st[0])
         <= `MPS_SYNC_CYC, 1'b1);
      chk({tg[0], tg[1]}, 32'h00330044);
      wait_idle();
      dur <= 8'd200;
      for (k = 0; k < 4; k++)
      begin
         j = ns[0];
         run(8'd4, 2'b01, 1'b1);
         wait_n(0, j + 1);
         @(posedge pclk);
         if (k == 0)
            wr(`MPS_OFF_CTRL, ctl_x | 32'h4);
         else
            bad <= 7'h1 << (k == 1 ? 0 : k == 2 ? 5 : 6);
         repeat (4) @(negedge pclk);
         chk(program_active[0], 1'b0);
         @(posedge pclk);
         bad <= 7'h00;
         wr(`MPS_OFF_CTRL, ctl_x);
         wait_idle();
      end
      for (k = 0; k < 6; k++)
      begin
         @(posedge pclk);
         bad <= 7'h1 << k;
         run(8'd4, 2'b01, 1'b0);
         @(posedge pclk);
         bad <= 7'h00;
         wait_idle();
      end
      // sync in a single-axis program ends it with the error flag
      wr(`MPS_OFF_PROG, 32'h0005000A);
      j = ns[0];
      run(8'd5, 2'b01, 1'b1);
      wait_idle();
      apb(1'b0, `MPS_OFF_STAT, 32'h0, q);
      chk(q, 32'h204);
      chk(ns[0] - j, 0);
      wr(`MPS_OFF_LIM, 32'h10);
      j = ns[0];
      wr(`MPS_OFF_CTRL, ctl_x | 32'h0401);
      repeat (20) @(negedge pclk);
      wr(`MPS_OFF_CTRL, ctl_x);
      repeat (6) @(negedge pclk);
      chk(ns[0] - j, 0);
      chk(program_active, 2'b00);
      complete_run();
   end
   // hang guard, well beyond the expected run length
   initial
   begin
      #5000000;
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire
